// ===== chidc_pkg.sv
// Package for the card host interrupt mask, DMA and configuration register bank.
// Assumes a plain register port with word byte addresses at the printed offsets.
package chidc_pkg;
	localparam logic [31:0] CHIDC_ENABLE_ADDR = 32'h40000044;
	localparam logic [31:0] CHIDC_DISABLE_ADDR = 32'h40000048;
	localparam logic [31:0] CHIDC_MASK_ADDR = 32'h4000004C;
	localparam logic [31:0] CHIDC_DMA_ADDR = 32'h40000050;
	localparam logic [31:0] CHIDC_CFG_ADDR = 32'h40000054;
	localparam logic [31:0] CHIDC_WP_ADDR = 32'h400000E4;
	localparam logic [31:0] CHIDC_STATUS_ADDR = 32'h40000040;
	localparam logic [31:0] CHIDC_IRQ_VALID = 32'hFFFF313F;
	localparam logic [23:0] CHIDC_WP_KEY = 24'h4D4349;
	localparam int CHIDC_WP_EN_BIT = 0;
	localparam int CHIDC_WP_KEY_LSB = 8;
	localparam int CHIDC_OFFSET_LSB = 0;
	localparam int CHIDC_CHUNK_BIT = 4;
	localparam int CHIDC_HANDSHAKE_BIT = 8;
	localparam int CHIDC_PAD_BIT = 12;
	localparam int CHIDC_START_MODE_BIT = 0;
	localparam int CHIDC_FERR_BIT = 4;
	localparam int CHIDC_HS_BIT = 8;
	localparam int CHIDC_LAST_SYNC_BIT = 12;
	localparam int CHIDC_OVR_BIT = 30;
	localparam int CHIDC_UNR_BIT = 31;
	localparam logic [31:0] CHIDC_MASK_RESET = 32'h00000000;
	localparam logic [31:0] CHIDC_DMA_RESET = 32'h00000000;
	localparam logic [31:0] CHIDC_CFG_RESET = 32'h00000000;
	localparam logic [31:0] CHIDC_DMA_VALID = 32'h00001113;
	localparam logic [31:0] CHIDC_CFG_VALID = 32'h00001111;

	typedef struct packed {
		logic [1:0] write_offset;
		logic chunk_size;
		logic dma_handshake_enable;
		logic read_padding;
		logic fifo_start_mode;
		logic flow_error_clear_mode;
		logic high_speed_timing;
		logic last_block_sync;
	} chidc_cfg_t;
endpackage

// ===== chidc_bank.sv
// Register bank for the card host: interrupt mask, DMA setup and general configuration.
// Assumes single-cycle strobes on ref_clk_i and status sources from the same clock domain.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module chidc_bank
	import chidc_pkg::*;
#(
	parameter int FIFO_BYTES = 1024,
	parameter int LEN_W = 16
) (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Register port.
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Status sources and data path inputs.
	input wire logic [31:0] status_set_i,
	input wire logic [31:0] status_level_i,
	input wire logic data_cmd_i,
	input wire logic [LEN_W-1:0] block_length_i,
	input wire logic [LEN_W-1:0] fifo_level_i,
	input wire logic write_xfer_i,
	// Decoded controls.
	output chidc_cfg_t cfg_o,
	output logic [LEN_W-1:0] read_len_o,
	output logic write_start_o,
	output logic dma_req_o,
	output logic write_protect_on_o,
	output logic irq_o
);
	logic [31:0] interrupt_mask;
	logic [31:0] dma_config;
	logic [31:0] host_config;
	logic [31:0] status_flags;
	logic write_protect_on;
	logic [LEN_W-1:0] dma_avail;

	wire sel_en = addr_i == CHIDC_ENABLE_ADDR;
	wire sel_dis = addr_i == CHIDC_DISABLE_ADDR;
	wire sel_mask = addr_i == CHIDC_MASK_ADDR;
	wire sel_dma = addr_i == CHIDC_DMA_ADDR;
	wire sel_cfg = addr_i == CHIDC_CFG_ADDR;
	wire sel_wp = addr_i == CHIDC_WP_ADDR;
	wire sel_stat = addr_i == CHIDC_STATUS_ADDR;
	wire wr_en = wr_i && sel_en;
	wire wr_dis = wr_i && sel_dis;
	wire wr_dma = wr_i && sel_dma && !write_protect_on;
	wire wr_cfg = wr_i && sel_cfg && !write_protect_on;
	wire wr_wp = wr_i && sel_wp && wdata_i[31:CHIDC_WP_KEY_LSB] == CHIDC_WP_KEY;
	wire rd_stat = rd_i && sel_stat;
	wire [31:0] en_bits = wr_en ? (wdata_i & CHIDC_IRQ_VALID) : 32'h00000000;
	wire [31:0] dis_bits = wr_dis ? (wdata_i & CHIDC_IRQ_VALID) : 32'h00000000;
	wire [31:0] next_mask = (interrupt_mask | en_bits) & ~dis_bits;
	wire ferr_mode = host_config[CHIDC_FERR_BIT];
	wire [31:0] flow_bits = (32'h1 << CHIDC_OVR_BIT) | (32'h1 << CHIDC_UNR_BIT);
	wire [31:0] flow_clr = (data_cmd_i && !ferr_mode) || (rd_stat && ferr_mode)
		? flow_bits : 32'h00000000;
	wire [31:0] next_flags = ((status_flags & ~flow_clr) | status_set_i) & CHIDC_IRQ_VALID;
	wire [31:0] stat_view = status_flags | status_level_i;
	wire [31:0] next_rdata = sel_mask ? interrupt_mask :
		sel_dma ? (dma_config & CHIDC_DMA_VALID) :
		sel_cfg ? (host_config & CHIDC_CFG_VALID) :
		sel_wp ? {31'h0, write_protect_on} :
		sel_stat ? (stat_view & CHIDC_IRQ_VALID) : 32'h00000000;
	wire [LEN_W-1:0] pad_len = (block_length_i + LEN_W'(3)) & ~LEN_W'(3);
	wire [LEN_W-1:0] next_read_len = dma_config[CHIDC_PAD_BIT] ? pad_len : block_length_i;
	wire [LEN_W-1:0] thresh = (32'(block_length_i) * 4 >= FIFO_BYTES * 3) ? LEN_W'(FIFO_BYTES / 2) :
		(32'(block_length_i) * 2 >= FIFO_BYTES) ? LEN_W'(FIFO_BYTES / 4) : block_length_i;
	wire next_start = write_xfer_i && (host_config[CHIDC_START_MODE_BIT] ?
		fifo_level_i != '0 : (fifo_level_i >= thresh && fifo_level_i != '0));
	wire [LEN_W-1:0] chunk = dma_config[CHIDC_CHUNK_BIT] ? LEN_W'(4) : LEN_W'(1);
	wire next_dma_req = dma_config[CHIDC_HANDSHAKE_BIT] && fifo_level_i >= chunk;
	wire next_irq = |(stat_view & next_mask & CHIDC_IRQ_VALID);
	chidc_cfg_t next_cfg;

	assign dma_avail = fifo_level_i;
	assign next_cfg = '{
		write_offset: dma_config[CHIDC_OFFSET_LSB+1:CHIDC_OFFSET_LSB],
		chunk_size: dma_config[CHIDC_CHUNK_BIT],
		dma_handshake_enable: dma_config[CHIDC_HANDSHAKE_BIT],
		read_padding: dma_config[CHIDC_PAD_BIT],
		fifo_start_mode: host_config[CHIDC_START_MODE_BIT],
		flow_error_clear_mode: ferr_mode,
		high_speed_timing: host_config[CHIDC_HS_BIT],
		last_block_sync: host_config[CHIDC_LAST_SYNC_BIT]
	};

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			interrupt_mask <= CHIDC_MASK_RESET;
			dma_config <= CHIDC_DMA_RESET;
			host_config <= CHIDC_CFG_RESET;
			status_flags <= 32'h00000000;
			write_protect_on <= 1'b0;
		end else begin
			interrupt_mask <= next_mask;
			status_flags <= next_flags;
			if (wr_dma) begin
				dma_config <= wdata_i & CHIDC_DMA_VALID;
			end
			if (wr_cfg) begin
				host_config <= wdata_i & CHIDC_CFG_VALID;
			end
			if (wr_wp) begin
				write_protect_on <= wdata_i[CHIDC_WP_EN_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			rdata_o <= 32'h00000000;
			cfg_o <= '0;
			read_len_o <= '0;
			write_start_o <= 1'b0;
			dma_req_o <= 1'b0;
			write_protect_on_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? next_rdata : 32'h00000000;
			cfg_o <= next_cfg;
			read_len_o <= next_read_len;
			write_start_o <= next_start;
			dma_req_o <= next_dma_req && dma_avail != '0;
			write_protect_on_o <= write_protect_on;
			irq_o <= next_irq;
		end
	end

	// Checks on the mask, configuration and flag logic.
	sequence s_protect_write;
		write_protect_on && wr_i && (sel_dma || sel_cfg);
	endsequence

	sequence s_flow_read;
		rd_stat && ferr_mode;
	endsequence

	sequence s_data_cmd;
		data_cmd_i && !ferr_mode;
	endsequence

	chk_disable_clears: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_dis |=> ((interrupt_mask & $past(wdata_i) & CHIDC_IRQ_VALID) == 32'h0))
		else $error("Disable write left a mask bit set.");

	chk_disable_keeps: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_dis |=> ((interrupt_mask & ~$past(wdata_i)) == ($past(interrupt_mask) & ~$past(wdata_i))))
		else $error("Disable write changed a mask bit written as zero.");

	chk_enable_sets: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_en && !wr_dis |=> ((~interrupt_mask & $past(wdata_i) & CHIDC_IRQ_VALID) == 32'h0))
		else $error("Enable write left a mask bit clear.");

	chk_enable_keeps: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_en |=> (($past(interrupt_mask) & ~interrupt_mask) == 32'h0))
		else $error("Enable write cleared a mask bit.");

	chk_mask_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!wr_en && !wr_dis |=> $stable(interrupt_mask))
		else $error("Mask changed without an enable or disable write.");

	chk_mask_reserved: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(interrupt_mask & ~CHIDC_IRQ_VALID) == 32'h0)
		else $error("Reserved mask bit set.");

	chk_mask_readback: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_i && sel_mask |=> rdata_o == $past(interrupt_mask))
		else $error("Mask read data wrong.");

	chk_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!rd_i |=> rdata_o == 32'h00000000)
		else $error("Read data not zero outside a read.");

	chk_unmapped_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_i && !sel_mask && !sel_dma && !sel_cfg && !sel_wp && !sel_stat
		|=> rdata_o == 32'h00000000)
		else $error("Unmapped read returned data.");

	chk_status_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_stat |=> rdata_o == ($past(stat_view) & CHIDC_IRQ_VALID))
		else $error("Status read data wrong.");

	chk_protect_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		write_protect_on && wr_i && sel_cfg |=> $stable(host_config))
		else $error("Protected config changed.");

	chk_dma_protect: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		s_protect_write |=> $stable(dma_config) && $stable(host_config))
		else $error("Protected register changed.");

	chk_dma_accept: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_dma |=> dma_config == ($past(wdata_i) & CHIDC_DMA_VALID))
		else $error("Unprotected DMA write not taken.");

	chk_cfg_accept: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_cfg |=> host_config == ($past(wdata_i) & CHIDC_CFG_VALID))
		else $error("Unprotected config write not taken.");

	chk_protect_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		1'b1 |=> write_protect_on_o == $past(write_protect_on))
		else $error("Protection output does not follow its state.");

	chk_key_refused: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_i && sel_wp && (wdata_i[31:CHIDC_WP_KEY_LSB] != CHIDC_WP_KEY)
		|=> $stable(write_protect_on))
		else $error("Protection changed by a write with a wrong key.");

	chk_key_accepted: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wr_wp |=> (($past(wdata_i) >> CHIDC_WP_EN_BIT) & 32'h00000001) == {31'h0, write_protect_on})
		else $error("Keyed protection write not taken.");

	chk_pad_round: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		dma_config[CHIDC_PAD_BIT] |=> read_len_o[1:0] == 2'h0)
		else $error("Padded length not a multiple of four.");

	chk_exact_len: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!dma_config[CHIDC_PAD_BIT] |=> read_len_o == $past(block_length_i))
		else $error("Unpadded length differs from block length.");

	chk_dma_gate: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!dma_config[CHIDC_HANDSHAKE_BIT] |=> !dma_req_o)
		else $error("DMA request while handshake disabled.");

	chk_chunk_one: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		dma_config[CHIDC_HANDSHAKE_BIT] && !dma_config[CHIDC_CHUNK_BIT] && (fifo_level_i != '0)
		|=> dma_req_o)
		else $error("DMA request missing with one data available.");

	chk_chunk_four: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		dma_config[CHIDC_CHUNK_BIT] && (fifo_level_i < LEN_W'(4)) |=> !dma_req_o)
		else $error("DMA request with fewer than four data.");

	chk_start_any: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		host_config[CHIDC_START_MODE_BIT] && write_xfer_i && (fifo_level_i != '0)
		|=> write_start_o)
		else $error("Write start missing with data in the FIFO.");

	chk_start_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!write_xfer_i || (fifo_level_i == '0) |=> !write_start_o)
		else $error("Write start without pending transfer or data.");

	chk_start_half: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!host_config[CHIDC_START_MODE_BIT] && write_xfer_i
		&& (32'(block_length_i) * 4 >= FIFO_BYTES * 3)
		&& (fifo_level_i >= LEN_W'(FIFO_BYTES / 2)) |=> write_start_o)
		else $error("Write start missing at half FIFO for a long block.");

	chk_offset_field: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		1'b1 |=> cfg_o.write_offset == 2'($past(dma_config) >> CHIDC_OFFSET_LSB))
		else $error("Offset output wrong.");

	chk_speed_field: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		1'b1 |=> cfg_o.high_speed_timing == 1'($past(host_config) >> CHIDC_HS_BIT))
		else $error("High-speed output wrong.");

	chk_sync_field: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		1'b1 |=> cfg_o.last_block_sync == 1'($past(host_config) >> CHIDC_LAST_SYNC_BIT))
		else $error("Last-block sync output wrong.");

	chk_flow_read_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		rd_stat && ferr_mode && !status_set_i[CHIDC_OVR_BIT] |=> !status_flags[CHIDC_OVR_BIT])
		else $error("Overrun flag survived status read.");

	chk_flow_read_unr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		s_flow_read ##0 !status_set_i[CHIDC_UNR_BIT] |=> !status_flags[CHIDC_UNR_BIT])
		else $error("Underrun flag survived status read.");

	chk_flow_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		status_flags[CHIDC_UNR_BIT] && !ferr_mode && !data_cmd_i |=> status_flags[CHIDC_UNR_BIT])
		else $error("Underrun flag cleared without data command.");

	chk_cmd_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		s_data_cmd ##0 !status_set_i[CHIDC_UNR_BIT] |=> !status_flags[CHIDC_UNR_BIT])
		else $error("Underrun flag survived a data command.");

	chk_set_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		status_set_i[CHIDC_OVR_BIT] |=> status_flags[CHIDC_OVR_BIT])
		else $error("Overrun event lost.");

	chk_flag_reserved: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(status_flags & ~CHIDC_IRQ_VALID) == 32'h0)
		else $error("Reserved status flag set.");

	chk_irq_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		next_irq |=> irq_o)
		else $error("Interrupt output missed an enabled flag.");

	chk_irq_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		!next_irq |=> !irq_o)
		else $error("Interrupt output without an enabled flag.");
endmodule

// ===== chidc_card_model.sv
// Card-side event source that registers each request and drives it as a status pulse one cycle later, for as many cycles as it is held.
// Assumes the same clock and reset as the register bank.
`timescale 1ns/1ps
module chidc_card_model (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Event request and status pulse.
	input wire logic [31:0] event_i,
	output logic [31:0] status_set_o
);
	always_ff @(posedge ref_clk_i) begin
		status_set_o <= reset_i ? 32'h00000000 : event_i;
	end
endmodule

// ===== card_host_irq_dma_config_tb.sv
// Self-checking bench for the card host register bank.
// Assumes a small FIFO size so that start thresholds stay short.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD t=%0t got %0h exp %0h", $time, a, b); end end
module card_host_irq_dma_config_tb;
	import chidc_pkg::*;
	logic ref_clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, rd_d = 0, data_cmd_i = 0;
	logic write_xfer_i = 0, dma_req_o, write_start_o, write_protect_on_o, irq_o;
	logic [31:0] addr_i = 0, wdata_i = 0, rdata_o, status_level_i = 0, ev = 0, st_set;
	logic [31:0] rng = 32'hC475, v, m, e;
	logic [15:0] block_length_i = 16'h0005, fifo_level_i = 0, read_len_o;
	logic [15:0] bl [3] = '{16'h0030, 16'h0020, 16'h000A};
	logic [15:0] th [3] = '{16'h0020, 16'h0010, 16'h000A};
	logic [31:0] exp_q [$];
	chidc_cfg_t cfg_o;
	int n_fail = 0, samples_checked = 0, cyc = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	chidc_card_model card (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .event_i(ev),
		.status_set_o(st_set));
	chidc_bank #(.FIFO_BYTES(64), .LEN_W(16)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.status_set_i(st_set), .status_level_i(status_level_i), .data_cmd_i(data_cmd_i),
		.block_length_i(block_length_i), .fifo_level_i(fifo_level_i),
		.write_xfer_i(write_xfer_i), .cfg_o(cfg_o), .read_len_o(read_len_o),
		.write_start_o(write_start_o), .dma_req_o(dma_req_o),
		.write_protect_on_o(write_protect_on_o), .irq_o(irq_o));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1;
		@(posedge ref_clk_i);
		wr_i <= 0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] x);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1;
		exp_q.push_back(x);
		@(posedge ref_clk_i);
		rd_i <= 0;
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask
	task automatic pulse(input logic [31:0] p);
		@(posedge ref_clk_i);
		ev <= p;
		@(posedge ref_clk_i);
		ev <= 0;
		settle();
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge ref_clk_i) begin
		rd_d <= rd_i;
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			stop_test();
		end
	end
	always @(negedge ref_clk_i) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			`CHK(rdata_o, e)
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 0;
		rd(CHIDC_MASK_ADDR, CHIDC_MASK_RESET);
		rd(CHIDC_DMA_ADDR, CHIDC_DMA_RESET);
		rd(CHIDC_CFG_ADDR, CHIDC_CFG_RESET);
		rd(32'h40000100, 32'h00000000);
		v = xs();
		m = v & CHIDC_IRQ_VALID;
		wr(CHIDC_ENABLE_ADDR, v);
		rd(CHIDC_MASK_ADDR, m);
		v = xs();
		wr(CHIDC_DISABLE_ADDR, v);
		rd(CHIDC_MASK_ADDR, m & ~v);
		wr(CHIDC_DISABLE_ADDR, 32'hFFFFFFFF);
		rd(CHIDC_MASK_ADDR, 32'h00000000);
		$display("mask test done");
		wr(CHIDC_DMA_ADDR, xs() | 32'h00001113);
		rd(CHIDC_DMA_ADDR, 32'h00001113);
		fifo_level_i <= 16'h0003;
		settle();
		`CHK(cfg_o.write_offset, 2'h3)
		`CHK(cfg_o, 9'h1F0)
		`CHK(read_len_o, 16'h0008)
		`CHK(dma_req_o, 1'b0)
		@(posedge ref_clk_i);
		fifo_level_i <= 16'h0004;
		settle();
		`CHK(dma_req_o, 1'b1)
		wr(CHIDC_DMA_ADDR, 32'h00000100);
		fifo_level_i <= 16'h0001;
		settle();
		`CHK(dma_req_o, 1'b1)
		`CHK(read_len_o, 16'h0005)
		wr(CHIDC_DMA_ADDR, 32'h00000000);
		settle();
		`CHK(dma_req_o, 1'b0)
		$display("dma test done");
		wr(CHIDC_CFG_ADDR, 32'h00001111);
		write_xfer_i <= 1;
		settle();
		`CHK(cfg_o.high_speed_timing, 1'b1)
		`CHK(cfg_o.last_block_sync, 1'b1)
		`CHK(write_start_o, 1'b1)
		`CHK(cfg_o, 9'h00F)
		wr(CHIDC_CFG_ADDR, 32'h00000000);
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk_i);
			block_length_i <= bl[i];
			fifo_level_i <= th[i] - 16'h0001;
			settle();
			`CHK(write_start_o, 1'b0)
			@(posedge ref_clk_i);
			fifo_level_i <= th[i];
			settle();
			`CHK(write_start_o, 1'b1)
		end
		$display("start test done");
		wr(CHIDC_WP_ADDR, 32'h12345601);
		wr(CHIDC_DMA_ADDR, 32'h00000010);
		rd(CHIDC_DMA_ADDR, 32'h00000010);
		wr(CHIDC_WP_ADDR, {CHIDC_WP_KEY, 8'h01});
		wr(CHIDC_DMA_ADDR, 32'h00000000);
		wr(CHIDC_CFG_ADDR, 32'h00000001);
		rd(CHIDC_DMA_ADDR, 32'h00000010);
		rd(CHIDC_CFG_ADDR, 32'h00000000);
		settle();
		`CHK(write_protect_on_o, 1'b1)
		wr(CHIDC_WP_ADDR, {CHIDC_WP_KEY, 8'h00});
		$display("protect test done");
		status_level_i <= 32'h00000010;
		wr(CHIDC_ENABLE_ADDR, 32'hC0000000);
		wr(CHIDC_CFG_ADDR, 32'h00000010);
		pulse(32'h40000000);
		`CHK(irq_o, 1'b1)
		rd(CHIDC_STATUS_ADDR, 32'h40000010);
		rd(CHIDC_STATUS_ADDR, 32'h00000010);
		settle();
		`CHK(irq_o, 1'b0)
		wr(CHIDC_CFG_ADDR, 32'h00000000);
		pulse(32'h80000000);
		rd(CHIDC_STATUS_ADDR, 32'h80000010);
		rd(CHIDC_STATUS_ADDR, 32'h80000010);
		@(posedge ref_clk_i);
		data_cmd_i <= 1;
		@(posedge ref_clk_i);
		data_cmd_i <= 0;
		rd(CHIDC_STATUS_ADDR, 32'h00000010);
		settle();
		$display("flag test done");
		stop_test();
	end
endmodule
